// *** include/esp_pkg.sv ***
// Package for the serial slave front end of the memory device.
// Assumes a single core clock and synchronous active-high reset.
package esp_pkg;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam int SYNC_W = 4;
    // Synchroniser lane positions
    localparam int LANE_SEL_N = 0;
    localparam int LANE_SCK = 1;
    localparam int LANE_SIN = 2;
    localparam int LANE_PAUSE_N = 3;
    // Idle pin levels held in the synchroniser at reset: pause high, sel high
    localparam logic [SYNC_W-1:0] SYNC_RST = 4'h9;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_PAUSED
    } esp_state_e;
endpackage

// *** verilog/esp_sync.sv ***
// Two-stage synchroniser for a group of unrelated pin levels.
// Assumes each lane is an independent level from outside the clock domain.
module esp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// *** verilog/esp_slave.sv ***
// Serial slave port: select, standby, bit shifting, pause and output drive.
// Assumes pins are asynchronous to clk and the serial clock is far slower.
// Contract
// R1: The internal logic is active only while chip select is held low.
// R2: Chip select high deselects the port and puts it in standby.
// R3: While deselected, serial input activity is ignored entirely.
// R4: While deselected, the serial output is not driven.
// R5: Output bits change on falling serial clock edges.
// R6: The output pull-up is on only in ultra-deep power-down.
// R7: Input bits are sampled on rising serial clock edges.
// R8: Pause low suspends the transfer and keeps the bit position.
// R9: Modes 0 and 3 both work with the same edge usage.
// R10: In mode 0 the master keeps the serial clock low while deselected.
// R11: In mode 3 the master keeps the serial clock high while deselected.
// R12: The master keeps all inputs at valid levels at all times.
// R13: Each transfer starts with an 8-bit instruction from the first rising edge.
// R14: All bytes move most significant bit first.
// R15: Selecting the port clears the bit counter and any partial instruction.
module esp_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic sel_n_pin,
    input wire logic sck_pin,
    input wire logic serial_in,
    input wire logic pause_n_pin,
    input wire logic deep_pd,
    input wire logic drive_en,
    input wire logic [esp_pkg::BYTE_W-1:0] tx_data,
    output logic serial_out,
    output logic serial_out_oe,
    output logic serial_out_pu,
    output logic [esp_pkg::BYTE_W-1:0] rx_byte,
    output logic rx_valid,
    output logic rx_first,
    output logic tx_take,
    output logic selected,
    output logic paused
);
    logic [esp_pkg::SYNC_W-1:0] pins_s;
    logic sel_n_s;
    logic sck_s;
    logic sin_s;
    logic pause_n_s;
    logic sck_prev_q;
    logic sck_rise;
    logic sck_fall;

    esp_pkg::esp_state_e state_q, state_d;
    logic [esp_pkg::BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic [esp_pkg::BYTE_W-1:0] rx_sh_q, rx_sh_d;
    logic [esp_pkg::BYTE_W-1:0] rx_byte_q, rx_byte_d;
    logic rx_valid_q, rx_valid_d;
    logic rx_first_q, rx_first_d;
    logic first_q, first_d;
    logic [esp_pkg::BYTE_W-1:0] tx_sh_q, tx_sh_d;
    logic tx_pend_q, tx_pend_d;
    logic tx_take_q, tx_take_d;
    logic out_q, out_d;
    logic oe_q, oe_d;
    logic pu_q, pu_d;

    esp_sync #(
        .W(esp_pkg::SYNC_W),
        .RST_VAL(esp_pkg::SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({pause_n_pin, serial_in, sck_pin, sel_n_pin}),
        .q(pins_s)
    );

    assign sel_n_s = pins_s[esp_pkg::LANE_SEL_N];
    assign sck_s = pins_s[esp_pkg::LANE_SCK];
    assign sin_s = pins_s[esp_pkg::LANE_SIN];
    assign pause_n_s = pins_s[esp_pkg::LANE_PAUSE_N];
    // Edges found on the synchronised serial clock
    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        rx_sh_d = rx_sh_q;
        rx_byte_d = rx_byte_q;
        rx_valid_d = 1'b0;
        rx_first_d = rx_first_q;
        first_d = first_q;
        tx_sh_d = tx_sh_q;
        tx_pend_d = tx_pend_q;
        tx_take_d = 1'b0;
        out_d = out_q;
        case (state_q)
            esp_pkg::ST_STANDBY: begin // R3
                if (!sel_n_s) begin
                    state_d = esp_pkg::ST_ACTIVE; // R1
                    bit_cnt_d = esp_pkg::BIT_CNT_RST; // R15
                    rx_sh_d = esp_pkg::BYTE_RST; // R15
                    first_d = 1'b1; // R13
                    tx_pend_d = 1'b0;
                end
            end
            esp_pkg::ST_ACTIVE: begin
                if (sel_n_s) begin
                    state_d = esp_pkg::ST_STANDBY; // R2
                end else if (!pause_n_s) begin
                    state_d = esp_pkg::ST_PAUSED; // R8
                end else if (sck_rise) begin
                    // Same edges for modes 0 and 3; a leading mode 3 fall is harmless
                    rx_sh_d = {rx_sh_q[esp_pkg::BYTE_W-2:0], sin_s}; // R7 R14 R9
                    bit_cnt_d = bit_cnt_q + 3'h1;
                    if (bit_cnt_q == esp_pkg::BIT_CNT_LAST) begin
                        rx_byte_d = {rx_sh_q[esp_pkg::BYTE_W-2:0], sin_s};
                        rx_valid_d = 1'b1;
                        rx_first_d = first_q; // R13
                        first_d = 1'b0;
                        tx_pend_d = 1'b1;
                    end
                end else if (sck_fall) begin
                    if (tx_pend_q) begin
                        out_d = tx_data[esp_pkg::BYTE_W-1]; // R5 R14
                        tx_sh_d = {tx_data[esp_pkg::BYTE_W-2:0], 1'b0};
                        tx_pend_d = 1'b0;
                        tx_take_d = 1'b1;
                    end else begin
                        out_d = tx_sh_q[esp_pkg::BYTE_W-1]; // R5
                        tx_sh_d = {tx_sh_q[esp_pkg::BYTE_W-2:0], 1'b0};
                    end
                end
            end
            esp_pkg::ST_PAUSED: begin
                // Position frozen until pause is released
                if (sel_n_s) begin
                    state_d = esp_pkg::ST_STANDBY; // R2
                end else if (pause_n_s) begin
                    state_d = esp_pkg::ST_ACTIVE; // R8
                end
            end
            default: begin
                state_d = esp_pkg::ST_STANDBY;
            end
        endcase
        oe_d = (state_d == esp_pkg::ST_ACTIVE) && drive_en; // R4
        pu_d = deep_pd && !oe_d; // R6
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_prev_q <= 1'b0;
            state_q <= esp_pkg::ST_STANDBY;
            bit_cnt_q <= esp_pkg::BIT_CNT_RST;
            rx_sh_q <= esp_pkg::BYTE_RST;
            rx_byte_q <= esp_pkg::BYTE_RST;
            rx_valid_q <= 1'b0;
            rx_first_q <= 1'b0;
            first_q <= 1'b0;
            tx_sh_q <= esp_pkg::BYTE_RST;
            tx_pend_q <= 1'b0;
            tx_take_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            pu_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            rx_sh_q <= rx_sh_d;
            rx_byte_q <= rx_byte_d;
            rx_valid_q <= rx_valid_d;
            rx_first_q <= rx_first_d;
            first_q <= first_d;
            tx_sh_q <= tx_sh_d;
            tx_pend_q <= tx_pend_d;
            tx_take_q <= tx_take_d;
            out_q <= out_d;
            oe_q <= oe_d;
            pu_q <= pu_d;
        end
    end

    assign serial_out = out_q;
    assign serial_out_oe = oe_q;
    assign serial_out_pu = pu_q;
    assign rx_byte = rx_byte_q;
    assign rx_valid = rx_valid_q;
    assign rx_first = rx_first_q;
    assign tx_take = tx_take_q;
    assign selected = (state_q != esp_pkg::ST_STANDBY);
    assign paused = (state_q == esp_pkg::ST_PAUSED);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_select;
        state_q == esp_pkg::ST_STANDBY && !sel_n_s;
    endsequence

    sequence s_deselect;
        state_q != esp_pkg::ST_STANDBY && sel_n_s;
    endsequence

    property p_select_active;
        s_select |=> state_q == esp_pkg::ST_ACTIVE;
    endproperty
    a_select_active: assert property (p_select_active) // R1
        else $error("port not active after select");

    property p_standby_entry;
        s_deselect |=> state_q == esp_pkg::ST_STANDBY ##1 !oe_q;
    endproperty
    a_standby_entry: assert property (p_standby_entry) // R2
        else $error("port not in standby after deselect");

    property p_ignore_deselected;
        state_q == esp_pkg::ST_STANDBY |=> !rx_valid_q && $stable(rx_byte_q);
    endproperty
    a_ignore_deselected: assert property (p_ignore_deselected) // R3
        else $error("byte accepted while deselected");

    property p_tristate_deselected;
        sel_n_s |=> !oe_q;
    endproperty
    a_tristate_deselected: assert property (p_tristate_deselected) // R4
        else $error("output driven while deselected");

    property p_out_on_fall;
        !sck_fall |=> $stable(out_q);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) // R5
        else $error("output changed without falling edge");

    property p_pullup_udpd;
        pu_q |-> $past(deep_pd) && !oe_q;
    endproperty
    a_pullup_udpd: assert property (p_pullup_udpd) // R6
        else $error("pull-up on outside deep power-down");

    property p_sample_rise;
        rx_valid_q |-> $past(sck_rise) && rx_byte_q[0] == $past(sin_s);
    endproperty
    a_sample_rise: assert property (p_sample_rise) // R7
        else $error("byte completed without rising edge");

    property p_pause_keeps;
        state_q == esp_pkg::ST_PAUSED && !sel_n_s |=>
            $stable(bit_cnt_q) && $stable(rx_sh_q) && $stable(tx_sh_q);
    endproperty
    a_pause_keeps: assert property (p_pause_keeps) // R8
        else $error("position lost during pause");

    property p_fall_no_count;
        state_q == esp_pkg::ST_ACTIVE && sck_fall |=> $stable(bit_cnt_q);
    endproperty
    a_fall_no_count: assert property (p_fall_no_count) // R9
        else $error("falling edge counted as input bit");

    property p_first_byte;
        s_select |=> bit_cnt_q == esp_pkg::BIT_CNT_RST && first_q && !tx_pend_q;
    endproperty
    a_first_byte: assert property (p_first_byte) // R15
        else $error("select did not clear bit position");

    property p_instr_flag;
        rx_valid_q && rx_first_q |-> $past(first_q);
    endproperty
    a_instr_flag: assert property (p_instr_flag) // R13
        else $error("instruction flag on a later byte");

    property p_msb_first;
        rx_valid_q |-> rx_byte_q[7:1] == $past(rx_sh_q[6:0]);
    endproperty
    a_msb_first: assert property (p_msb_first) // R14
        else $error("byte not assembled msb first");
endmodule

// *** verification/esp_master.sv ***
// Behavioural serial master driving the slave port pins.
// Assumes the core clock is given; pins change at its falling edge.
module esp_master (
    input wire logic clk,
    input wire logic miso,
    output logic sel_n,
    output logic sck,
    output logic mosi,
    output logic pause_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        pause_n = 1'b1;
    end
    // Half a serial clock period: 80 ns
    task automatic half();
        repeat (10) @(negedge clk);
    endtask
    task automatic idle(input logic pol);
        cpol = pol;
        sel_n = 1'b1;
        sck = pol;
        half();
    endtask
    task automatic select();
        sel_n = 1'b0;
        half();
    endtask
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            mosi = tx[7-i];
            half();
            sck = 1'b1;
            rx = {rx[6:0], miso};
            half();
        end
    endtask
    task automatic hold(input logic on);
        pause_n = ~on;
        half();
    endtask
    task automatic tick();
        sck = ~sck;
        half();
    endtask
    task automatic deselect();
        sck = cpol;
        half();
        sel_n = 1'b1;
        mosi = ~mosi;
        half();
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the serial slave port.
// Assumes the master model drives pins; the core side is driven here.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic deep_pd = 1'b0;
    logic drive_en = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic sel_n, sck, mosi, pause_n, so, oe, pu, miso, last_q = 1'b0;
    logic rx_valid, rx_first, tx_take, selected, paused;
    logic [7:0] rx_byte, got, rx_cnt = 8'h00, n0;
    logic [7:0] tk_cnt = 8'h00;
    logic [7:0] n1;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    // Released line shows inverse of last driven value, or high while the pull-up is on
    assign miso = oe ? so : (pu ? 1'b1 : ~last_q);
    always @(posedge clk) begin
        if (oe) last_q <= so;
        if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 8'h01;
        if (tx_take === 1'b1) tk_cnt <= tk_cnt + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    esp_master m (.clk(clk), .miso(miso), .sel_n(sel_n), .sck(sck), .mosi(mosi),
        .pause_n(pause_n));
    esp_slave uut (.clk(clk), .rst(rst), .sel_n_pin(sel_n), .sck_pin(sck),
        .serial_in(mosi), .pause_n_pin(pause_n), .deep_pd(deep_pd),
        .drive_en(drive_en), .tx_data(tx_data), .serial_out(so),
        .serial_out_oe(oe), .serial_out_pu(pu), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_first(rx_first), .tx_take(tx_take),
        .selected(selected), .paused(paused));
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Clocking with select high must be ignored
    task automatic t_deselected(input logic pol);
        m.idle(pol);
        n0 = rx_cnt;
        drive_en = 1'b1;
        m.bits(8'hFF, 8, got);
        m.idle(pol);
        chk8(rx_cnt, n0);
        chk1(oe, 1'b0);
        chk1(selected, 1'b0);
        drive_en = 1'b0;
    endtask
    task automatic t_xfer(input logic pol, input logic [7:0] ins, input logic [7:0] dat,
        input logic [7:0] rsp);
        m.idle(pol);
        m.select();
        chk1(selected, 1'b1);
        n0 = rx_cnt;
        m.bits(ins, 8, got);
        chk8(rx_byte, ins);
        chk1(rx_first, 1'b1);
        chk8(rx_cnt, n0 + 8'h01);
        drive_en = 1'b1;
        tx_data = rsp;
        n1 = tk_cnt;
        m.bits(dat, 8, got);
        chk8(got, rsp);
        chk8(tk_cnt, n1 + 8'h01);
        chk1(oe, 1'b1);
        chk8(rx_byte, dat);
        chk1(rx_first, 1'b0);
        m.deselect();
        chk1(oe, 1'b0);
        chk1(selected, 1'b0);
        drive_en = 1'b0;
    endtask
    // Deselect in mid-byte, then a fresh instruction
    task automatic t_partial();
        m.idle(1'b0);
        m.select();
        m.bits(8'hF0, 4, got);
        m.deselect();
        m.select();
        n0 = rx_cnt;
        m.bits(8'h81, 8, got);
        chk8(rx_byte, 8'h81);
        chk1(rx_first, 1'b1);
        chk8(rx_cnt, n0 + 8'h01);
        m.deselect();
    endtask
    // Pause after 3 bits, clock while paused, then finish the byte
    task automatic t_pause();
        m.idle(1'b1);
        m.select();
        drive_en = 1'b1;
        m.bits(8'hA0, 3, got);
        m.hold(1'b1);
        chk1(paused, 1'b1);
        chk1(oe, 1'b0);
        m.tick();
        m.tick();
        m.hold(1'b0);
        chk1(paused, 1'b0);
        m.bits(8'h38, 5, got);
        chk8(rx_byte, 8'hA7);
        chk1(rx_first, 1'b1);
        drive_en = 1'b0;
        m.deselect();
    endtask
    task automatic t_pullup();
        m.idle(1'b0);
        deep_pd = 1'b1;
        repeat (4) @(negedge clk);
        chk1(pu, 1'b1);
        chk1(miso, 1'b1);
        deep_pd = 1'b0;
        repeat (4) @(negedge clk);
        chk1(pu, 1'b0);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_deselected(1'b0);
        t_deselected(1'b1);
        t_xfer(1'b0, 8'h03, 8'hC3, 8'h3C);
        t_xfer(1'b1, 8'h05, 8'h5A, 8'hA5);
        t_partial();
        t_pause();
        t_pullup();
        conclude();
    end
endmodule
